// File: svp_cfg.svh
// constants for the servo pid host port: codes, field positions, timing
`ifndef SVP_CFG_SVH
`define SVP_CFG_SVH
`define SVP_CLK_MHZ 250
`define SVP_BUSY_US 20
`define SVP_SAMPLE_CYC 2048
`define SVP_STROBE_CYC 8
`define SVP_ZERO8 8'h80
`define SVP_ZERO12 12'h800
`define SVP_ISHIFT 8
`define SVP_ST_BUSY 0
`define SVP_ST_BRK 6
`define SVP_ST_ERR 5
`define SVP_OP_ADDR 4'h0
`define SVP_RES_ADDR 4'h4
`define SVP_OP_KIND_HI 9
`define SVP_OP_KIND_LO 8
`define SVP_LOAD_FILTER_CMD_WORDS 4'h5
`endif

// File: svp_pkg.sv
// types shared by both ends of the servo pid host port
package svp_pkg;
   // command byte codes
   typedef enum logic [7:0] {
      SVP_RESET_CMD = 8'h00, SVP_SELECT_NARROW = 8'h05, SVP_SELECT_WIDE = 8'h06,
      SVP_DEFINE_HOME = 8'h02, SVP_ARM_INDEX = 8'h03, SVP_ERR_FLAG = 8'h1b,
      SVP_ERR_STOP = 8'h1a, SVP_BRK_ABS = 8'h20, SVP_BRK_REL = 8'h21,
      SVP_LOAD_FILTER = 8'h1e, SVP_APPLY_FILTER = 8'h04
   } svp_cmd_t;
   // host port cycle kinds
   typedef enum logic [1:0] {
      SVP_K_CMD_WR = 2'h0, SVP_K_STAT_RD = 2'h1, SVP_K_DATA_WR = 2'h2, SVP_K_DATA_RD = 2'h3
   } svp_kind_t;
endpackage : svp_pkg

// File: svp_port_if.sv
// parallel host port wires between host and servo device
`timescale 1ns/1ps
`default_nettype none
interface svp_port_if;
   logic port_select_n;
   logic rd_n;
   logic wr_n;
   logic [7:0] host_data;
   logic host_oe_n;
   logic [7:0] dev_data;
   logic dev_oe_n;
   modport device (input port_select_n, rd_n, wr_n, host_data, host_oe_n, output dev_data, dev_oe_n);
   modport host (output port_select_n, rd_n, wr_n, host_data, host_oe_n, input dev_data, dev_oe_n);
endinterface : svp_port_if
`default_nettype wire

// File: svp_device.sv
// servo device end: host port decoder, pid filter and motor outputs
//
// Summary of operation
// RULE_01: saturate position error to signed 16 bits
// RULE_02: filter products keep low 16 bits only
// RULE_03: 24-bit integral accumulator, upper 16 used
// RULE_04: integral bits shifted right eight before gain
// RULE_05: integral product limited by integration limit magnitude
// RULE_06: derivative product formed per interval, added every sample
// RULE_07: sum terms, drive upper 8 or 12 bits
// RULE_08: command byte taken on write strobe rising edge
// RULE_09: select low reads status, high moves data
// RULE_10: host checks busy low before command write
// RULE_11: busy never above 100 us, about 20
// RULE_12: data words are two bytes, high first
// RULE_13: host checks busy before every byte pair
// RULE_14: command written while busy is discarded
// RULE_15: busy rises after command or second byte
// RULE_16: output latched 8-bit or multiplexed 12-bit
// RULE_17: external 6-bit latch rebuilds the 12-bit word
// RULE_18: offset binary output, zero 80 or 800
// RULE_19: pwm variant gives 8-bit magnitude plus sign
// RULE_20: decode 00 05 06 02 03 1b 1a 20 21
// RULE_21: status read served by hardware, no command
// RULE_22: error is desired minus actual position
// RULE_23: reset clears coefficients, narrow width, zero output
// RULE_24: previous boundary error held for derivative
`timescale 1ns/1ps
`default_nettype none
`include "svp_cfg.svh"
module svp_device #(
   parameter int BUSY_CYCLES = `SVP_BUSY_US * `SVP_CLK_MHZ,
   parameter int SAMPLE_CYCLES = `SVP_SAMPLE_CYC
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // host port
   svp_port_if.device port,
   // loop positions
   input wire logic [31:0] i_desired_pos,
   input wire logic [31:0] i_actual_pos,
   // converter output
   output logic [7:0] o_dac,
   output logic o_dac_hi_latch,
   output logic o_dac_load,
   output logic o_select_wide_output,
   // pulse-width output
   output logic o_pwm_mag,
   output logic o_pwm_sign
);
   // low 16 bits of a 16x16 product
   function automatic logic [15:0] mul16(input logic [15:0] a, input logic [15:0] b);
      logic [31:0] p;
      p = a * b;
      return p[15:0];
   endfunction : mul16

   logic [2:0] ps_s_q, rd_s_q, wr_s_q;
   logic [7:0] din_s1_q, din_s2_q;
   logic wr_rise, rd_rise, ps_lo, rd_lo;
   logic busy_q;
   logic [15:0] busy_cnt_q;
   logic [7:0] cmd_q, hi_byte_q, wr_hi_q;
   logic [3:0] words_left_q;
   logic [2:0] word_idx_q;
   logic wbyte2_q, rbyte2_q;
   logic [15:0] intv_b_q, kp_b_q, ki_b_q, kd_b_q, il_b_q;
   logic [15:0] kp_q, ki_q, kd_q, il_q;
   logic [7:0] intv_q, dcnt_q;
   logic [15:0] thresh_q;
   logic stop_on_err_q, err_flag_q, brk_flag_q, wide_q;
   logic [31:0] brk_q;
   logic [15:0] samp_cnt_q;
   logic tick;
   logic [23:0] integ_q, integ_d;
   logic signed [15:0] err, prev_err_q, dprod_q, iprod, ilim, u_d;
   logic [15:0] iabs;
   logic signed [32:0] diff;
   logic [7:0] dev_data_q;
   logic dev_oe_n_q;
   logic [11:0] code12_q;
   logic [1:0] mux_ph_q;
   logic [7:0] pwm_cnt_q, pwm_mag_q;
   logic [7:0] status;
   logic word_done, cmd_take;
   logic [15:0] word_in;

   // strobes and data are pins: two flops before any use, third for edges
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ps_s_q <= 3'h7;
         rd_s_q <= 3'h7;
         wr_s_q <= 3'h7;
         din_s1_q <= 8'h00;
         din_s2_q <= 8'h00;
      end else begin
         ps_s_q <= {ps_s_q[1:0], port.port_select_n};
         rd_s_q <= {rd_s_q[1:0], port.rd_n};
         wr_s_q <= {wr_s_q[1:0], port.wr_n};
         din_s1_q <= port.host_data;
         din_s2_q <= din_s1_q;
      end
   end
   assign ps_lo = ~ps_s_q[1];
   assign rd_lo = ~rd_s_q[1];
   assign wr_rise = wr_s_q[1] & ~wr_s_q[2]; // see RULE_08
   assign rd_rise = rd_s_q[1] & ~rd_s_q[2];
   assign cmd_take = wr_rise & ps_lo & ~busy_q; // see RULE_14
   assign word_in = {wr_hi_q, din_s2_q}; // see RULE_12
   assign word_done = ~ps_lo & ((wr_rise & wbyte2_q & (words_left_q != 4'h0)) | (rd_rise & rbyte2_q));
   assign status = {1'b0, brk_flag_q, err_flag_q, 4'h0, busy_q};

   // busy raised by a command or a finished word, released by timer
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy_q <= 1'b0;
         busy_cnt_q <= 16'h0000;
      end else if (cmd_take | word_done) begin
         busy_q <= 1'b1; // see RULE_15
         busy_cnt_q <= 16'h0000;
      end else if (busy_q) begin
         busy_cnt_q <= busy_cnt_q + 16'h0001;
         if (busy_cnt_q >= 16'(BUSY_CYCLES - 1)) busy_q <= 1'b0; // see RULE_11
      end
   end

   // byte pairing per direction; a command restarts both
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wbyte2_q <= 1'b0;
         rbyte2_q <= 1'b0;
         wr_hi_q <= 8'h00;
      end else if (cmd_take) begin
         wbyte2_q <= 1'b0;
         rbyte2_q <= 1'b0;
      end else if (!ps_lo) begin
         if (wr_rise) begin
            wbyte2_q <= ~wbyte2_q; // see RULE_12
            if (!wbyte2_q) wr_hi_q <= din_s2_q;
         end
         if (rd_rise) rbyte2_q <= ~rbyte2_q;
      end
   end

   // command decode, data word routing and configuration
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmd_q <= 8'h00;
         words_left_q <= 4'h0;
         word_idx_q <= 3'h0;
         {intv_b_q, kp_b_q, ki_b_q, kd_b_q, il_b_q} <= 80'h0; // see RULE_23
         {kp_q, ki_q, kd_q, il_q} <= 64'h0;
         intv_q <= 8'h00;
         thresh_q <= 16'h7fff;
         stop_on_err_q <= 1'b0;
         brk_q <= 32'h0000_0000;
         wide_q <= 1'b0;
      end else if (cmd_take) begin
         cmd_q <= din_s2_q;
         word_idx_q <= 3'h0;
         words_left_q <= 4'h0;
         unique case (din_s2_q) // see RULE_20
            svp_pkg::SVP_RESET_CMD: begin
               {intv_b_q, kp_b_q, ki_b_q, kd_b_q, il_b_q} <= 80'h0; // see RULE_23
               {kp_q, ki_q, kd_q, il_q} <= 64'h0;
               intv_q <= 8'h00;
               wide_q <= 1'b0;
               stop_on_err_q <= 1'b0;
            end
            svp_pkg::SVP_SELECT_NARROW: wide_q <= 1'b0;
            svp_pkg::SVP_SELECT_WIDE: wide_q <= 1'b1;
            svp_pkg::SVP_ERR_FLAG, svp_pkg::SVP_ERR_STOP: words_left_q <= 4'h1;
            svp_pkg::SVP_BRK_ABS, svp_pkg::SVP_BRK_REL: words_left_q <= 4'h2;
            svp_pkg::SVP_LOAD_FILTER: words_left_q <= `SVP_LOAD_FILTER_CMD_WORDS;
            svp_pkg::SVP_APPLY_FILTER: begin
               {kp_q, ki_q, kd_q, il_q} <= {kp_b_q, ki_b_q, kd_b_q, il_b_q};
               intv_q <= intv_b_q[7:0];
            end
            default: ; // home and index arm only raise busy and restart byte pairing in this device
         endcase
      end else if (word_done && wr_rise) begin
         words_left_q <= words_left_q - 4'h1;
         word_idx_q <= word_idx_q + 3'h1;
         unique case (cmd_q)
            svp_pkg::SVP_ERR_FLAG, svp_pkg::SVP_ERR_STOP: begin
               thresh_q <= word_in;
               stop_on_err_q <= (cmd_q == svp_pkg::SVP_ERR_STOP);
            end
            svp_pkg::SVP_BRK_ABS: begin
               if (word_idx_q == 3'h0) brk_q[31:16] <= word_in;
               else brk_q[15:0] <= word_in;
            end
            svp_pkg::SVP_BRK_REL: begin
               if (word_idx_q == 3'h0) brk_q[31:16] <= word_in;
               else brk_q <= {brk_q[31:16], word_in} + i_desired_pos;
            end
            svp_pkg::SVP_LOAD_FILTER: begin
               unique case (word_idx_q)
                  3'h0: intv_b_q <= word_in;
                  3'h1: kp_b_q <= word_in;
                  3'h2: ki_b_q <= word_in;
                  3'h3: kd_b_q <= word_in;
                  default: il_b_q <= word_in;
               endcase
            end
            default: ;
         endcase
      end
   end

   // sample tick
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) samp_cnt_q <= 16'h0000;
      else if (tick) samp_cnt_q <= 16'h0000;
      else samp_cnt_q <= samp_cnt_q + 16'h0001;
   end
   assign tick = samp_cnt_q >= 16'(SAMPLE_CYCLES - 1);

   // pid arithmetic for one sample
   always_comb begin
      diff = 33'(signed'(i_desired_pos)) - 33'(signed'(i_actual_pos)); // see RULE_22
      if (diff > 33'sh0_7fff) err = 16'sh7fff; // see RULE_01
      else if (diff < -33'sh0_8000) err = -16'sh8000;
      else err = diff[15:0];
      integ_d = integ_q + {{8{err[15]}}, err}; // see RULE_03
      iprod = mul16(16'(signed'(integ_d[23:8]) >>> `SVP_ISHIFT), ki_q); // see RULE_04
      iabs = iprod[15] ? 16'(-iprod) : iprod;
      ilim = (iabs < il_q) ? iprod : (iprod[15] ? 16'(-il_q) : il_q); // see RULE_05
      u_d = mul16(err, kp_q) + ilim + dprod_q; // see RULE_02 RULE_07
   end

   // filter state and sticky status events
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         integ_q <= 24'h000000;
         prev_err_q <= 16'sh0000;
         dprod_q <= 16'sh0000;
         dcnt_q <= 8'h00;
         code12_q <= `SVP_ZERO12;
         err_flag_q <= 1'b0;
         brk_flag_q <= 1'b0;
      end else begin
         if (cmd_take && din_s2_q == svp_pkg::SVP_RESET_CMD) begin
            err_flag_q <= 1'b0;
            brk_flag_q <= 1'b0;
            integ_q <= 24'h000000;
            code12_q <= `SVP_ZERO12;
         end else if (tick) begin
            integ_q <= integ_d;
            if (stop_on_err_q && err_flag_q) code12_q <= `SVP_ZERO12;
            else code12_q <= u_d[15:4] ^ `SVP_ZERO12; // see RULE_07 RULE_18
            if (dcnt_q >= intv_q) begin
               dcnt_q <= 8'h00;
               dprod_q <= mul16(err - prev_err_q, kd_q); // see RULE_06
               prev_err_q <= err; // see RULE_24
            end else begin
               dcnt_q <= dcnt_q + 8'h01;
            end
         end
         if (tick && (err[15] ? 16'(-err) : err) > thresh_q) err_flag_q <= 1'b1;
         if (tick && i_actual_pos == brk_q) brk_flag_q <= 1'b1;
      end
   end

   // 8-bit latched or 12-bit as two 6-bit halves; hi half goes to the latch
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_dac <= `SVP_ZERO8;
         mux_ph_q <= 2'h0;
         o_dac_hi_latch <= 1'b0;
         o_dac_load <= 1'b0;
      end else begin
         o_dac_hi_latch <= 1'b0;
         o_dac_load <= 1'b0;
         if (!wide_q) begin
            o_dac <= code12_q[11:4]; // see RULE_16
         end else begin
            mux_ph_q <= mux_ph_q + 2'h1;
            if (mux_ph_q == 2'h0) begin
               o_dac <= {2'h0, code12_q[11:6]}; // see RULE_17
               o_dac_hi_latch <= 1'b1;
            end else if (mux_ph_q == 2'h2) begin
               o_dac <= {2'h1, code12_q[5:0]};
               o_dac_load <= 1'b1;
            end
         end
      end
   end
   assign o_select_wide_output = wide_q;

   // sign/magnitude pwm from the 8-bit code
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pwm_cnt_q <= 8'h00;
         pwm_mag_q <= 8'h00;
         o_pwm_mag <= 1'b0;
         o_pwm_sign <= 1'b0;
      end else begin
         pwm_cnt_q <= pwm_cnt_q + 8'h01;
         if (pwm_cnt_q == 8'hff) begin
            o_pwm_sign <= ~code12_q[11]; // see RULE_19
            pwm_mag_q <= code12_q[11] ? {1'b0, code12_q[10:4]} : 8'(8'h80 - code12_q[11:4]);
         end
         o_pwm_mag <= pwm_cnt_q < pwm_mag_q;
      end
   end

   // read drive: status with select low, integral word bytes with select high
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dev_data_q <= 8'h00;
         dev_oe_n_q <= 1'b1;
         hi_byte_q <= 8'h00;
      end else begin
         dev_oe_n_q <= ~rd_lo;
         if (ps_lo) dev_data_q <= status; // see RULE_21 RULE_09
         else if (!rbyte2_q) dev_data_q <= integ_q[23:16];
         else dev_data_q <= hi_byte_q;
         if (!rbyte2_q) hi_byte_q <= integ_q[15:8];
      end
   end
   assign port.dev_data = dev_data_q;
   assign port.dev_oe_n = dev_oe_n_q;
endmodule : svp_device
`default_nettype wire

// File: svp_host.sv
// host end: avalon-mm command registers driving the parallel port
`timescale 1ns/1ps
`default_nettype none
`include "svp_cfg.svh"
module svp_host (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // parallel port
   svp_port_if.host port
);
   typedef enum {SVP_IDLE, SVP_POLL_LO, SVP_POLL_GAP, SVP_ACT_LO, SVP_ACT_GAP} svp_hstate_t;
   svp_hstate_t st_q;
   svp_pkg::svp_kind_t kind_q;
   logic [7:0] byte_q, result_q, din_s1_q, din_s2_q;
   logic [4:0] cnt_q;
   logic pair2_q, rd_ack_q, start, cnt_end;

   assign start = i_avs_write & (i_avs_address == `SVP_OP_ADDR) & (st_q == SVP_IDLE);
   assign cnt_end = cnt_q == 5'(`SVP_STROBE_CYC - 1);
   // writes stall while a port cycle runs; reads take one wait cycle
   assign o_avs_waitrequest = (i_avs_write & (i_avs_address == `SVP_OP_ADDR) & (st_q != SVP_IDLE))
                            | (i_avs_read & ~rd_ack_q);

   // device data is a pin: two flops
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         din_s1_q <= 8'h00;
         din_s2_q <= 8'h00;
      end else begin
         din_s1_q <= port.dev_data;
         din_s2_q <= din_s1_q;
      end
   end

   // port cycle sequencer; polls busy before commands and each word
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q <= SVP_IDLE;
         kind_q <= svp_pkg::SVP_K_STAT_RD;
         byte_q <= 8'h00;
         result_q <= 8'h00;
         cnt_q <= 5'h00;
         pair2_q <= 1'b0;
      end else begin
         cnt_q <= cnt_end ? 5'h00 : cnt_q + 5'h01;
         unique case (st_q)
            SVP_IDLE: begin
               cnt_q <= 5'h00;
               if (start) begin
                  kind_q <= svp_pkg::svp_kind_t'(i_avs_writedata[`SVP_OP_KIND_HI:`SVP_OP_KIND_LO]);
                  byte_q <= i_avs_writedata[7:0];
                  if (i_avs_writedata[`SVP_OP_KIND_HI:`SVP_OP_KIND_LO] == svp_pkg::SVP_K_STAT_RD ||
                      (i_avs_writedata[`SVP_OP_KIND_HI] && pair2_q)) st_q <= SVP_ACT_LO;
                  else st_q <= SVP_POLL_LO; // see RULE_10 RULE_13
               end
            end
            SVP_POLL_LO: if (cnt_end) st_q <= SVP_POLL_GAP;
            SVP_POLL_GAP: if (cnt_end) st_q <= din_s2_q[`SVP_ST_BUSY] ? SVP_POLL_LO : SVP_ACT_LO;
            SVP_ACT_LO: begin
               if (cnt_end) begin
                  st_q <= SVP_ACT_GAP;
                  if (kind_q[0]) result_q <= din_s2_q;
                  if (kind_q == svp_pkg::SVP_K_CMD_WR) pair2_q <= 1'b0;
                  else if (kind_q[1]) pair2_q <= ~pair2_q; // see RULE_12
               end
            end
            SVP_ACT_GAP: if (cnt_end) st_q <= SVP_IDLE;
         endcase
      end
   end

   // avalon read answer
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_ack_q <= 1'b0;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         rd_ack_q <= i_avs_read & ~rd_ack_q;
         if (i_avs_address == `SVP_OP_ADDR) o_avs_readdata <= {30'h0, pair2_q, st_q != SVP_IDLE};
         else if (i_avs_address == `SVP_RES_ADDR) o_avs_readdata <= {24'h0, result_q};
         else o_avs_readdata <= 32'h0000_0000;
      end
   end

   // pin drive; data held through gaps so it is stable at the strobe edge
   assign port.port_select_n = (st_q == SVP_POLL_LO || st_q == SVP_POLL_GAP) ? 1'b0 : kind_q[1];
   assign port.rd_n = ~(st_q == SVP_POLL_LO || (st_q == SVP_ACT_LO && kind_q[0])); // see RULE_09
   assign port.wr_n = ~(st_q == SVP_ACT_LO && !kind_q[0]); // see RULE_08
   assign port.host_data = byte_q;
   assign port.host_oe_n = ~((st_q == SVP_ACT_LO || st_q == SVP_ACT_GAP) && !kind_q[0]);
endmodule : svp_host
`default_nettype wire

// File: svp_port_props.sv
// checker for the parallel port wires between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module svp_port_props #(
   parameter int BUSY_CYCLES = 60,
   parameter int BUSY_LIMIT = 124
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // port wires
   input wire logic port_select_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] host_data,
   input wire logic host_oe_n,
   input wire logic [7:0] dev_data,
   input wire logic dev_oe_n
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   logic busy_q;
   logic [15:0] busy_age_q;
   logic [15:0] cmd_age_q;
   // busy bit of the last status read; a stuck flag shows as a growing age
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy_q <= 1'b0;
      end else if ($rose(rd_n) && !port_select_n && !dev_oe_n) begin
         busy_q <= dev_data[0];
      end
   end
   // age of the busy flag as the host sees it
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy_age_q <= 16'h0;
      end else begin
         busy_age_q <= busy_q ? busy_age_q + 16'h1 : 16'h0;
      end
   end
   // cycles since the last command byte, saturating
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmd_age_q <= 16'hffff;
      end else if ($rose(wr_n) && !port_select_n) begin
         cmd_age_q <= 16'h0;
      end else if (cmd_age_q != 16'hffff) begin
         cmd_age_q <= cmd_age_q + 16'h1;
      end
   end
   sequence s_wr_strobe;
      !wr_n [*8] ##1 wr_n;
   endsequence
   sequence s_dev_on;
      ##[1:5] !dev_oe_n;
   endsequence
   property p_wr_len;
      $fell(wr_n) |-> s_wr_strobe;
   endproperty
   property p_wr_hold;
      (!wr_n && !$past(wr_n)) |-> ($stable(host_data) && $stable(port_select_n) && !host_oe_n);
   endproperty
   property p_wr_rise;
      $rose(wr_n) |-> (!host_oe_n && $stable(host_data));
   endproperty
   property p_strobes;
      !(!rd_n && !wr_n);
   endproperty
   property p_one_driver;
      !(!host_oe_n && !dev_oe_n);
   endproperty
   property p_stat_drive;
      ($fell(rd_n) && !port_select_n) |-> s_dev_on;
   endproperty
   property p_rd_release;
      $rose(rd_n) |-> ##[0:5] dev_oe_n;
   endproperty
   property p_busy_cmd;
      ($rose(rd_n) && !port_select_n && cmd_age_q > 16'd8 && cmd_age_q < BUSY_CYCLES) |-> dev_data[0];
   endproperty
   property p_busy_max;
      busy_age_q < BUSY_LIMIT;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
   a_wr_hold: assert property (p_wr_hold) else $error("write data moved in strobe");
   a_wr_rise: assert property (p_wr_rise) else $error("data gone at strobe rise");
   a_strobes: assert property (p_strobes) else $error("both strobes low");
   a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
   a_stat_drive: assert property (p_stat_drive) else $error("status not driven");
   a_rd_release: assert property (p_rd_release) else $error("data bus not released");
   a_busy_cmd: assert property (p_busy_cmd) else $error("busy low after command");
   a_busy_max: assert property (p_busy_max) else $error("busy held too long");
endmodule : svp_port_props
`default_nettype wire

// File: svp_tb_top.sv
// testbench: host end and device end joined over the parallel port
`timescale 1ns/1ps
`default_nettype none
module svp_tb_top;
   localparam int BUSY = 60;
   localparam int SAMPLE = 64;
   typedef struct {logic [31:0] in; logic [7:0] exp;} svp_row_t;
   logic i_ref_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] desired = 32'h0;
   logic [31:0] actual = 32'h0;
   logic [7:0] dac;
   logic hi_latch;
   logic load;
   logic wide;
   logic [7:0] st;
   logic pwm_mag;
   logic pwm_sign;
   int hi_cnt = 0;
   int n_mismatch = 0;
   int compares = 0;
   // command code beside the width it leaves selected
   svp_row_t cmds [6] = '{'{32'h06, 8'h1}, '{32'h05, 8'h0}, '{32'h06, 8'h1}, '{32'h00, 8'h0},
      '{32'h02, 8'h0}, '{32'h03, 8'h0}};
   // position error beside the narrow code it gives with a gain of 0x0100
   svp_row_t errs [6] = '{'{32'h1, 8'h81}, '{32'h100, 8'h80}, '{32'h12345, 8'h7f},
      '{32'hffffffff, 8'h7f}, '{32'hfffffffe, 8'h7e}, '{32'hfffedcbb, 8'h80}};
   always #2 i_ref_clk = ~i_ref_clk;
   svp_port_if svp_port_if_i ();
   svp_host svp_host_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .port(svp_port_if_i.host));
   svp_device #(.BUSY_CYCLES(BUSY), .SAMPLE_CYCLES(SAMPLE)) svp_device_i (.i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n), .port(svp_port_if_i.device), .i_desired_pos(desired), .i_actual_pos(actual),
      .o_dac(dac), .o_dac_hi_latch(hi_latch), .o_dac_load(load), .o_select_wide_output(wide),
      .o_pwm_mag(pwm_mag), .o_pwm_sign(pwm_sign));
   svp_port_props #(.BUSY_CYCLES(BUSY), .BUSY_LIMIT(BUSY + 64)) svp_port_props_i (.i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n), .port_select_n(svp_port_if_i.port_select_n), .rd_n(svp_port_if_i.rd_n),
      .wr_n(svp_port_if_i.wr_n), .host_data(svp_port_if_i.host_data), .host_oe_n(svp_port_if_i.host_oe_n),
      .dev_data(svp_port_if_i.dev_data), .dev_oe_n(svp_port_if_i.dev_oe_n));
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic timeout();
      n_mismatch++;
      $display("unexpected at %0t: wait ran out", $time);
      summarize();
   endtask : timeout
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one avalon cycle; request stands until the edge that samples waitrequest low
   task automatic avs_cycle(input logic wr, input logic [3:0] addr, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      avs_address <= addr;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      for (n = 0; n < 2000; n++) begin
         @(posedge i_ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n == 2000) timeout();
      @(posedge i_ref_clk);
   endtask : avs_cycle
   // one port operation, then wait for the host sequencer to go idle
   task automatic op(input logic [1:0] kind, input logic [7:0] b);
      logic [31:0] r;
      int n;
      avs_cycle(1'b1, 4'h0, {22'h0, kind, b}, r);
      r = 32'h1;
      for (n = 0; n < 500 && r[0] !== 1'b0; n++) avs_cycle(1'b0, 4'h0, 32'h0, r);
      if (r[0] !== 1'b0) timeout();
   endtask : op
   // read status until the device is no longer busy
   task automatic stat_idle();
      logic [31:0] r;
      int n;
      st = 8'hff;
      for (n = 0; n < 50 && st[0] !== 1'b0; n++) begin
         op(svp_pkg::SVP_K_STAT_RD, 8'h00);
         avs_cycle(1'b0, 4'h4, 32'h0, r);
         st = r[7:0];
      end
      if (st[0] !== 1'b0) timeout();
   endtask : stat_idle
   task automatic word(input logic [15:0] w);
      op(svp_pkg::SVP_K_DATA_WR, w[15:8]);
      op(svp_pkg::SVP_K_DATA_WR, w[7:0]);
   endtask : word
   task automatic cmd(input logic [7:0] c);
      op(svp_pkg::SVP_K_CMD_WR, c);
   endtask : cmd
   task automatic settle();
      repeat (3 * SAMPLE) @(posedge i_ref_clk);
   endtask : settle
   // loads gain 0x0100 with the other terms zero, then applies it
   task automatic load_filter();
      cmd(8'h1e);
      word(16'h0000);
      word(16'h0100);
      word(16'h0000);
      word(16'h0000);
      word(16'h0000);
      cmd(8'h04);
   endtask : load_filter
   // wide mode zero code must show in both halves of the multiplex
   task automatic wide_zero();
      int n;
      int seen;
      seen = 0;
      for (n = 0; n < 40 && seen != 3; n++) begin
         @(negedge i_ref_clk);
         if (load === 1'b1) begin
            chk(dac, 8'h40);
            seen |= 1;
         end
         if (hi_latch === 1'b1) begin
            chk({2'b00, dac[5:0]}, 8'h20);
            seen |= 2;
         end
      end
      if (seen != 3) timeout();
      @(posedge i_ref_clk);
   endtask : wide_zero
   initial begin
      repeat (3) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      @(posedge i_ref_clk);
      chk(dac, 8'h80);
      chk({7'h0, wide}, 8'h00);
      $display("test reset done");
      foreach (cmds[i]) begin
         cmd(cmds[i].in[7:0]);
         stat_idle();
         chk({7'h0, wide}, cmds[i].exp);
         if (cmds[i].exp[0]) wide_zero();
      end
      $display("test command table done");
      load_filter();
      cmd(8'h1a);
      word(16'h0010);
      desired <= 32'h8;
      settle();
      chk(dac, 8'h88);
      desired <= 32'h20;
      settle();
      chk(dac, 8'h80);
      stat_idle();
      chk({7'h0, st[5]}, 8'h01);
      desired <= 32'h1;
      cmd(8'h00);
      settle();
      stat_idle();
      chk({7'h0, st[5]}, 8'h00);
      chk(dac, 8'h80);
      $display("test stop and reset done");
      load_filter();
      foreach (errs[i]) begin
         desired <= errs[i].in;
         settle();
         chk(dac, errs[i].exp);
      end
      $display("test error table done");
      cmd(8'h1b);
      word(16'h0010);
      desired <= 32'h20;
      settle();
      chk(dac, 8'ha0);
      repeat (256) @(posedge i_ref_clk);
      repeat (256) @(posedge i_ref_clk) hi_cnt += pwm_mag;
      chk(8'(hi_cnt), 8'h20);
      chk({7'h0, pwm_sign}, 8'h00);
      stat_idle();
      chk({7'h0, st[5]}, 8'h01);
      actual <= 32'h7;
      cmd(8'h00);
      stat_idle();
      chk({7'h0, st[6]}, 8'h00);
      cmd(8'h20);
      word(16'h0000);
      word(16'h0005);
      actual <= 32'h5;
      settle();
      stat_idle();
      chk({7'h0, st[6]}, 8'h01);
      cmd(8'h21);
      word(16'h0000);
      word(16'h0002);
      actual <= 32'h22;
      settle();
      stat_idle();
      chk({7'h0, st[6]}, 8'h01);
      $display("test flags done");
      summarize();
   end
endmodule : svp_tb_top
`default_nettype wire
